// ==== design/fpec_class_core.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "fpec_map.svh"
// combinational classifier on a normalised field set
module fpec_class_core
  import fpec_pkg::*;
(
  input wire logic [14:0] expField,
  input wire logic [14:0] expOnes,
  input wire logic [62:0] fracField,
  input wire logic [62:0] fracMsbMask,
  input wire logic signBit,
  output logic [`FPEC_CLS_W-1:0] classVec
);
  // exponent extremes
  wire expZero = (expField == 15'h0000);
  wire expMax = (expField == expOnes);
  wire fracZero = (fracField == 63'h0);
  // quiet marker is the fraction msb
  wire fracTop = |(fracField & fracMsbMask);
  // all fraction bits except the msb
  wire fracRest = |(fracField & ~fracMsbMask);
  wire isNan = expMax & !fracZero;
  always_comb begin
    classVec = '0;
    classVec[`FPEC_CLS_ZERO] = expZero & fracZero; // [RULE6]
    classVec[`FPEC_CLS_DENORM] = expZero & !fracZero; // [RULE6]
    classVec[`FPEC_CLS_NORMAL] = !expZero & !expMax; // [RULE7]
    classVec[`FPEC_CLS_INF] = expMax & fracZero; // [RULE7]
    classVec[`FPEC_CLS_SNAN] = isNan & !fracTop; // [RULE8]
    classVec[`FPEC_CLS_QNAN] = isNan & fracTop; // [RULE8]
    // indefinite is a quiet nan, so both bits rise together
    classVec[`FPEC_CLS_INDEF] = isNan & fracTop & !fracRest & signBit; // [RULE9]
  end
endmodule
`default_nettype wire

// ==== design/fpec_top.sv ====
// Function
// RULE1: short formats store fraction, integer bit implied
// RULE2: extended integer bit 63, fraction msb 62
// RULE3: extended integer bit set except zero/denormal
// RULE4: exponent/fraction widths 5/10 8/23 11/52 15/63
// RULE5: unbias exponents by 15, 127, 1023, 16383
// RULE6: zero exponent: zero or denormal by fraction
// RULE7: middle exponents normal; max with zero fraction infinite
// RULE8: max exponent nonzero fraction: nan, msb quiet
// RULE9: indefinite: sign 1, ones exponent, fraction msb
// RULE10: storage bytes 2, 4, 8, 10
// RULE11: one-hot class registered one cycle later; an indefinite raises bit 6 together with the quiet nan bit 5
`timescale 1ns/1ns
`default_nettype none
`include "fpec_map.svh"
module fpec_top
  import fpec_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [79:0] opIn, // packed operand, right aligned
  input wire fpec_fmt_t fmtSel, // format of opIn
  input wire logic packSign, // pack path sign
  input wire logic [14:0] packExp, // pack path biased exponent
  input wire logic [62:0] packFrac, // pack path fraction, right aligned
  input wire logic packIndef, // pack the quiet indefinite instead
  output logic signOut,
  output logic [14:0] expOut, // biased exponent
  output logic signed [15:0] unbiasedExp,
  output logic intBit, // implied or explicit integer bit
  output logic [62:0] fracOut, // fraction, right aligned
  output logic [63:0] signifOut, // integer bit above the fraction
  output logic [`FPEC_CLS_W-1:0] classOut,
  output logic [3:0] byteCount,
  output logic [79:0] packOut,
  output logic intBitMismatch // extended integer bit contradicts class
);
  // per-format field widths
  wire isExt = (fmtSel == FPEC_EXT);
  wire isDouble = (fmtSel == FPEC_DOUBLE);
  wire isSingle = (fmtSel == FPEC_SINGLE);
  // unpack: exponent field per format [RULE4]
  wire [14:0] expHalf = {10'h000, opIn[14:10]};
  wire [14:0] expSingle = {7'h00, opIn[30:23]};
  wire [14:0] expDouble = {4'h0, opIn[62:52]};
  wire [14:0] expExt = opIn[78:64];
  wire [14:0] expSel = isExt ? expExt : isDouble ? expDouble : isSingle ? expSingle : expHalf; // [RULE4]
  // sign sits directly above the exponent [RULE4]
  wire signSel = isExt ? opIn[79] : isDouble ? opIn[63] : isSingle ? opIn[31] : opIn[15];
  // fraction per format, extended drops the integer bit [RULE2]
  wire [62:0] fracSel = isExt ? opIn[`FPEC_EXT_FRAC_MSB:0] :
    isDouble ? {11'h000, opIn[51:0]} :
    isSingle ? {40'h0, opIn[22:0]} : {53'h0, opIn[9:0]};
  // all-ones exponent pattern for the format
  wire [14:0] expOnes = isExt ? 15'h7FFF : isDouble ? 15'h07FF : isSingle ? 15'h00FF : 15'h001F;
  // msb of the fraction field, marks quiet nan
  wire [62:0] fracMsb = isExt ? 63'h4000000000000000 : isDouble ? 63'h0008000000000000 :
    isSingle ? 63'h0000000000400000 : 63'h0000000000000200;
  // bias per format [RULE5]
  wire [15:0] biasSel = isExt ? 16'(`FPEC_BIAS_EXT) : isDouble ? 16'(`FPEC_BIAS_DOUBLE) :
    isSingle ? 16'(`FPEC_BIAS_SINGLE) : 16'(`FPEC_BIAS_HALF);
  // subtraction gives true exponent; denormals keep raw field minus bias
  wire [15:0] unbiasNext = {1'b0, expSel} - biasSel; // [RULE5]
  // storage size per format [RULE10]
  wire [3:0] bytesSel = isExt ? 4'(`FPEC_BYTES_EXT) : isDouble ? 4'(`FPEC_BYTES_DOUBLE) :
    isSingle ? 4'(`FPEC_BYTES_SINGLE) : 4'(`FPEC_BYTES_HALF);
  // combinational class of the incoming operand
  logic [`FPEC_CLS_W-1:0] classNow;
  fpec_class_core uClass (
    .expField(expSel),
    .expOnes(expOnes),
    .fracField(fracSel),
    .fracMsbMask(fracMsb),
    .signBit(signSel),
    .classVec(classNow)
  );
  // implied bit is 1 unless zero exponent; short formats never store it [RULE1]
  wire impliedBit = (expSel != 15'h0000);
  // extended format carries its own integer bit in bit 63 [RULE2]
  wire intSel = isExt ? opIn[`FPEC_EXT_INT_BIT] : impliedBit; // [RULE1]
  // stored integer bit disagreeing with the field class flags an unsupported encoding
  wire mismatchNext = isExt & (opIn[`FPEC_EXT_INT_BIT] != impliedBit); // [RULE3]
  // pack path: indefinite overrides the requested fields [RULE9]
  wire pSign = packIndef ? 1'b1 : packSign;
  wire [14:0] pExp = packIndef ? expOnes : packExp;
  wire [62:0] pFrac = packIndef ? fracMsb : packFrac;
  // encoder drives integer bit from the exponent field [RULE3]
  wire pInt = (pExp != 15'h0000);
  wire [79:0] packHalf = {64'h0, pSign, pExp[4:0], pFrac[9:0]}; // [RULE1]
  wire [79:0] packSingle = {48'h0, pSign, pExp[7:0], pFrac[22:0]}; // [RULE1]
  wire [79:0] packDouble = {16'h0, pSign, pExp[10:0], pFrac[51:0]}; // [RULE1]
  wire [79:0] packExt = {pSign, pExp, pInt, pFrac}; // [RULE2] [RULE3]
  wire [79:0] packSel = isExt ? packExt : isDouble ? packDouble : isSingle ? packSingle : packHalf;
  // result registers, one cycle after the operand [RULE11]
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      signOut <= 1'b0;
      expOut <= 15'h0000;
      unbiasedExp <= 16'sh0000;
      intBit <= 1'b0;
      fracOut <= 63'h0;
      signifOut <= 64'h0;
      classOut <= '0;
      byteCount <= 4'h0;
      packOut <= 80'h0;
      intBitMismatch <= 1'b0;
    end else begin
      signOut <= signSel;
      expOut <= expSel;
      unbiasedExp <= $signed(unbiasNext);
      intBit <= intSel;
      fracOut <= fracSel;
      signifOut <= {intSel, fracSel};
      classOut <= classNow; // [RULE11]
      byteCount <= bytesSel; // [RULE10]
      packOut <= packSel;
      intBitMismatch <= mismatchNext;
    end
  end
  // class vector follows the operand by one cycle
  AST_CLASS_DELAY: assert property (@(posedge ref_clk) disable iff (rst) // [RULE11]
    !$past(rst) |-> classOut == $past(classNow))
    else $error("class vector not registered one cycle later");
  // exactly one primary class bit
  AST_ONE_HOT: assert property (@(posedge ref_clk) disable iff (rst) // [RULE11]
    !$past(rst) |-> $onehot(classOut[5:0]))
    else $error("class vector not one-hot");
  // a stored extended integer bit may contradict a zero field; that case must raise the flag
  AST_ZERO: assert property (@(posedge ref_clk) disable iff (rst) // [RULE6]
    (expSel == 15'h0000 && fracSel == 63'h0) |=> classOut[`FPEC_CLS_ZERO] && intBit == intBitMismatch)
    else $error("zero not classified");
  AST_INF: assert property (@(posedge ref_clk) disable iff (rst) // [RULE7]
    (expSel == expOnes && fracSel == 63'h0) |=> classOut[`FPEC_CLS_INF] && expOut != 15'h0000)
    else $error("infinity not classified");
  AST_QNAN: assert property (@(posedge ref_clk) disable iff (rst) // [RULE8]
    (expSel == expOnes && (fracSel & fracMsb) != 63'h0) |=> classOut[`FPEC_CLS_QNAN])
    else $error("quiet nan not classified");
  AST_BIAS: assert property (@(posedge ref_clk) disable iff (rst) // [RULE5]
    (fmtSel == FPEC_SINGLE) |=> unbiasedExp == $signed({1'b0, expOut}) - 16'sd127)
    else $error("single bias wrong");
  AST_BYTES: assert property (@(posedge ref_clk) disable iff (rst) // [RULE10]
    (fmtSel == FPEC_EXT) |=> byteCount == 4'hA)
    else $error("extended byte count wrong");
  AST_IMPLIED: assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
    (fmtSel == FPEC_DOUBLE && expSel != 15'h0000) |=> intBit && signifOut[63])
    else $error("implied integer bit missing");
  AST_INDEF: assert property (@(posedge ref_clk) disable iff (rst) // [RULE9]
    (packIndef && fmtSel == FPEC_SINGLE) |=> packOut[31:0] == 32'hFFC00000)
    else $error("indefinite pattern wrong");
  AST_EXT_INT: assert property (@(posedge ref_clk) disable iff (rst) // [RULE3]
    (fmtSel == FPEC_EXT && !packIndef && packExp == 15'h0000) |=> !packOut[63])
    else $error("extended integer bit set for zero exponent");

  // class checks beyond the basic ones above
  // zero exponent with some fraction bit set is a denormal
  AST_DENORM: assert property (@(posedge ref_clk) disable iff (rst) // [RULE6]
    (expSel == 15'h0000 && fracSel != 63'h0) |=> classOut[`FPEC_CLS_DENORM])
    else $error("denormal not classified");
  // half minus zero keeps its sign
  AST_NEG_ZERO: assert property (@(posedge ref_clk) disable iff (rst) // [RULE6]
    (fmtSel == FPEC_HALF && opIn[15:0] == 16'h8000) |=> classOut[`FPEC_CLS_ZERO] && signOut)
    else $error("minus zero lost its sign");
  // any exponent strictly between the extremes is normal
  AST_NORMAL: assert property (@(posedge ref_clk) disable iff (rst) // [RULE7]
    (expSel != 15'h0000 && expSel != expOnes) |=> classOut[`FPEC_CLS_NORMAL])
    else $error("normal not classified");
  // a normal never carries an upper class bit or a zero exponent
  AST_NORMAL_ALONE: assert property (@(posedge ref_clk) disable iff (rst) // [RULE7]
    classOut[`FPEC_CLS_NORMAL] |-> classOut[6:3] == 4'h0 && expOut != 15'h0000)
    else $error("normal overlaps another class");
  // max exponent, nonzero fraction, clear msb is signalling
  AST_SNAN: assert property (@(posedge ref_clk) disable iff (rst) // [RULE8]
    (expSel == expOnes && fracSel != 63'h0 && (fracSel & fracMsb) == 63'h0) |=> classOut[`FPEC_CLS_SNAN])
    else $error("signalling nan not classified");
  // a nan of either kind never has an empty fraction
  AST_NAN_FRAC: assert property (@(posedge ref_clk) disable iff (rst) // [RULE8]
    (classOut[`FPEC_CLS_SNAN] || classOut[`FPEC_CLS_QNAN]) |-> fracOut != 63'h0)
    else $error("nan with zero fraction");
  // negative quiet nan with only the msb set is the indefinite
  AST_INDEF_CLS: assert property (@(posedge ref_clk) disable iff (rst) // [RULE9]
    (signSel && expSel == expOnes && fracSel == fracMsb) |=> classOut[`FPEC_CLS_INDEF] && classOut[`FPEC_CLS_QNAN])
    else $error("indefinite not classified");
  // indefinite implies a negative quiet nan
  AST_INDEF_SIGN: assert property (@(posedge ref_clk) disable iff (rst) // [RULE9]
    classOut[`FPEC_CLS_INDEF] |-> signOut && classOut[`FPEC_CLS_QNAN])
    else $error("indefinite without sign or quiet bit");

  // sign sits right above the exponent, one check per format
  // half sign at bit 15
  AST_SIGN_HALF: assert property (@(posedge ref_clk) disable iff (rst) // [RULE4]
    (fmtSel == FPEC_HALF) |=> signOut == $past(opIn[15]))
    else $error("half sign wrong");
  // single sign at bit 31
  AST_SIGN_SINGLE: assert property (@(posedge ref_clk) disable iff (rst) // [RULE4]
    (fmtSel == FPEC_SINGLE) |=> signOut == $past(opIn[31]))
    else $error("single sign wrong");
  // double sign at bit 63
  AST_SIGN_DOUBLE: assert property (@(posedge ref_clk) disable iff (rst) // [RULE4]
    (fmtSel == FPEC_DOUBLE) |=> signOut == $past(opIn[63]))
    else $error("double sign wrong");
  // extended sign at bit 79
  AST_SIGN_EXT: assert property (@(posedge ref_clk) disable iff (rst) // [RULE4]
    (fmtSel == FPEC_EXT) |=> signOut == $past(opIn[79]))
    else $error("extended sign wrong");

  // exponent fields, zero extended to 15 bits
  // half exponent is 5 bits
  AST_EXP_HALF: assert property (@(posedge ref_clk) disable iff (rst) // [RULE4]
    (fmtSel == FPEC_HALF) |=> expOut == {10'h000, $past(opIn[14:10])})
    else $error("half exponent wrong");
  // single exponent is 8 bits
  AST_EXP_SINGLE: assert property (@(posedge ref_clk) disable iff (rst) // [RULE4]
    (fmtSel == FPEC_SINGLE) |=> expOut == {7'h00, $past(opIn[30:23])})
    else $error("single exponent wrong");
  // double exponent is 11 bits
  AST_EXP_DOUBLE: assert property (@(posedge ref_clk) disable iff (rst) // [RULE4]
    (fmtSel == FPEC_DOUBLE) |=> expOut == {4'h0, $past(opIn[62:52])})
    else $error("double exponent wrong");
  // extended exponent is 15 bits
  AST_EXP_EXT: assert property (@(posedge ref_clk) disable iff (rst) // [RULE4]
    (fmtSel == FPEC_EXT) |=> expOut == $past(opIn[78:64]))
    else $error("extended exponent wrong");

  // fraction fields, right aligned
  // half fraction is 10 bits
  AST_FRAC_HALF: assert property (@(posedge ref_clk) disable iff (rst) // [RULE4]
    (fmtSel == FPEC_HALF) |=> fracOut == {53'h0, $past(opIn[9:0])})
    else $error("half fraction wrong");
  // single fraction is 23 bits
  AST_FRAC_SINGLE: assert property (@(posedge ref_clk) disable iff (rst) // [RULE4]
    (fmtSel == FPEC_SINGLE) |=> fracOut == {40'h0, $past(opIn[22:0])})
    else $error("single fraction wrong");
  // double fraction is 52 bits
  AST_FRAC_DOUBLE: assert property (@(posedge ref_clk) disable iff (rst) // [RULE4]
    (fmtSel == FPEC_DOUBLE) |=> fracOut == {11'h000, $past(opIn[51:0])})
    else $error("double fraction wrong");
  // extended fraction stops below the integer bit
  AST_FRAC_EXT: assert property (@(posedge ref_clk) disable iff (rst) // [RULE2]
    (fmtSel == FPEC_EXT) |=> fracOut == $past(opIn[62:0]))
    else $error("extended fraction wrong");

  // integer bit handling
  // extended integer bit is taken from bit 63 as stored
  AST_EXT_INT_STORED: assert property (@(posedge ref_clk) disable iff (rst) // [RULE2]
    (fmtSel == FPEC_EXT) |=> intBit == $past(opIn[63]) && signifOut[63] == $past(opIn[63]))
    else $error("extended integer bit not taken from bit 63");
  // short formats imply a clear integer bit for a zero exponent
  AST_IMPLIED_ZERO: assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
    (fmtSel != FPEC_EXT && expSel == 15'h0000) |=> !intBit && !signifOut[63])
    else $error("implied integer bit set for zero exponent");
  // short formats never raise the stored bit flag
  AST_NO_FLAG_SHORT: assert property (@(posedge ref_clk) disable iff (rst) // [RULE3]
    (fmtSel != FPEC_EXT) |=> !intBitMismatch)
    else $error("integer bit flag raised for a short format");
  // encoder sets the extended integer bit for a nonzero exponent
  AST_EXT_INT_SET: assert property (@(posedge ref_clk) disable iff (rst) // [RULE3]
    (fmtSel == FPEC_EXT && !packIndef && packExp != 15'h0000) |=> packOut[63])
    else $error("extended integer bit clear for nonzero exponent");

  // bias per format, checked against the field just registered
  // half bias 15
  AST_BIAS_HALF: assert property (@(posedge ref_clk) disable iff (rst) // [RULE5]
    (fmtSel == FPEC_HALF) |=> unbiasedExp == $signed({1'b0, expOut}) - 16'sh000F)
    else $error("half bias wrong");
  // double bias 1023
  AST_BIAS_DOUBLE: assert property (@(posedge ref_clk) disable iff (rst) // [RULE5]
    (fmtSel == FPEC_DOUBLE) |=> unbiasedExp == $signed({1'b0, expOut}) - 16'sh03FF)
    else $error("double bias wrong");
  // extended bias 16383
  AST_BIAS_EXT: assert property (@(posedge ref_clk) disable iff (rst) // [RULE5]
    (fmtSel == FPEC_EXT) |=> unbiasedExp == $signed({1'b0, expOut}) - 16'sh3FFF)
    else $error("extended bias wrong");

  // storage sizes and packed widths
  // half uses two bytes
  AST_BYTES_HALF: assert property (@(posedge ref_clk) disable iff (rst) // [RULE10]
    (fmtSel == FPEC_HALF) |=> byteCount == 4'h2)
    else $error("half byte count wrong");
  // single uses four bytes
  AST_BYTES_SINGLE: assert property (@(posedge ref_clk) disable iff (rst) // [RULE10]
    (fmtSel == FPEC_SINGLE) |=> byteCount == 4'h4)
    else $error("single byte count wrong");
  // double uses eight bytes
  AST_BYTES_DOUBLE: assert property (@(posedge ref_clk) disable iff (rst) // [RULE10]
    (fmtSel == FPEC_DOUBLE) |=> byteCount == 4'h8)
    else $error("double byte count wrong");
  // packed half leaves everything above two bytes clear
  AST_PACK_HALF_WIDTH: assert property (@(posedge ref_clk) disable iff (rst) // [RULE10]
    (fmtSel == FPEC_HALF) |=> packOut[79:16] == 64'h0)
    else $error("half pack spills past two bytes");
  // packed single leaves everything above four bytes clear
  AST_PACK_SINGLE_WIDTH: assert property (@(posedge ref_clk) disable iff (rst) // [RULE10]
    (fmtSel == FPEC_SINGLE) |=> packOut[79:32] == 48'h0)
    else $error("single pack spills past four bytes");
  // packed double leaves everything above eight bytes clear
  AST_PACK_DOUBLE_WIDTH: assert property (@(posedge ref_clk) disable iff (rst) // [RULE10]
    (fmtSel == FPEC_DOUBLE) |=> packOut[79:64] == 16'h0)
    else $error("double pack spills past eight bytes");
  // packed half fields land with no integer bit stored
  AST_PACK_FIELDS_HALF: assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
    (fmtSel == FPEC_HALF && !packIndef) |=> packOut[15:0] == $past({packSign, packExp[4:0], packFrac[9:0]}))
    else $error("half pack fields misplaced");

  // indefinite patterns for the other formats
  // half indefinite
  AST_INDEF_HALF: assert property (@(posedge ref_clk) disable iff (rst) // [RULE9]
    (packIndef && fmtSel == FPEC_HALF) |=> packOut == 80'h0000000000000000FE00)
    else $error("half indefinite pattern wrong");
  // double indefinite
  AST_INDEF_DOUBLE: assert property (@(posedge ref_clk) disable iff (rst) // [RULE9]
    (packIndef && fmtSel == FPEC_DOUBLE) |=> packOut == 80'h0000FFF8000000000000)
    else $error("double indefinite pattern wrong");
  // extended indefinite also carries the integer bit
  AST_INDEF_EXT: assert property (@(posedge ref_clk) disable iff (rst) // [RULE9]
    (packIndef && fmtSel == FPEC_EXT) |=> packOut == 80'hFFFFC000000000000000)
    else $error("extended indefinite pattern wrong");
endmodule
`default_nettype wire

// ==== shared/fpec_map.svh ====
`ifndef FPEC_MAP_SVH
`define FPEC_MAP_SVH
// exponent widths per format
`define FPEC_EXPW_HALF 5
`define FPEC_EXPW_SINGLE 8
`define FPEC_EXPW_DOUBLE 11
`define FPEC_EXPW_EXT 15
// fraction widths per format
`define FPEC_FRACW_HALF 10
`define FPEC_FRACW_SINGLE 23
`define FPEC_FRACW_DOUBLE 52
`define FPEC_FRACW_EXT 63
// exponent biases
`define FPEC_BIAS_HALF 15
`define FPEC_BIAS_SINGLE 127
`define FPEC_BIAS_DOUBLE 1023
`define FPEC_BIAS_EXT 16383
// storage byte counts
`define FPEC_BYTES_HALF 2
`define FPEC_BYTES_SINGLE 4
`define FPEC_BYTES_DOUBLE 8
`define FPEC_BYTES_EXT 10
// extended format bit positions
`define FPEC_EXT_INT_BIT 63
`define FPEC_EXT_FRAC_MSB 62
// class vector bit positions
`define FPEC_CLS_ZERO 0
`define FPEC_CLS_DENORM 1
`define FPEC_CLS_NORMAL 2
`define FPEC_CLS_INF 3
`define FPEC_CLS_SNAN 4
`define FPEC_CLS_QNAN 5
`define FPEC_CLS_INDEF 6
`define FPEC_CLS_W 7
`endif

// ==== shared/fpec_pkg.sv ====
`default_nettype none
package fpec_pkg;
  // format select encoding
  typedef enum logic [1:0] {
    FPEC_HALF = 2'b00,
    FPEC_SINGLE = 2'b01,
    FPEC_DOUBLE = 2'b10,
    FPEC_EXT = 2'b11
  } fpec_fmt_t;
endpackage
`default_nettype wire

// ==== sim/fpec_src_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// far-side operand source: builds an encoding of the class asked for
module fpec_src_model
  import fpec_pkg::*;
(
  input wire fpec_fmt_t fmt, // format of the operand
  input wire logic [2:0] kind, // class bit position wanted
  input wire logic [79:0] rnd, // random filler bits
  output logic [79:0] opnd
);
  int EW[4] = '{5, 8, 11, 15};
  int FW[4] = '{10, 23, 52, 63};
  // fields are built apart, then shifted into place by format
  always_comb begin
    int ew, fw, ext;
    logic [14:0] ex;
    logic [62:0] fr;
    logic s;
    ew = EW[int'(fmt)];
    fw = FW[int'(fmt)];
    ext = (fmt == FPEC_EXT) ? 1 : 0;
    s = rnd[79];
    fr = rnd[62:0] & 63'((64'h1 << fw) - 64'h1);
    ex = 15'((32'h1 << ew) - 1);
    case (kind)
      3'h0: begin ex = 15'h0; fr = 63'h0; end
      3'h1: begin ex = 15'h0; fr[0] = 1'b1; end
      3'h2: ex = 15'(1 + int'(rnd[78:64]) % ((1 << ew) - 2));
      3'h3: fr = 63'h0;
      3'h4: begin fr[fw-1] = 1'b0; fr[0] = 1'b1; end
      3'h5: fr[fw-1] = 1'b1;
      default: begin s = 1'b1; fr = 63'h1 << (fw - 1); end
    endcase
    // integer bit kept consistent with the exponent, as a real source does
    opnd = (80'(s) << (ew + fw + ext)) | (80'(ex) << (fw + ext)) | 80'(fr);
    if (ext == 1) opnd[63] = (ex != 15'h0);
  end
endmodule
`default_nettype wire

// ==== sim/fpec_top_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module fpec_top_tb_top;
  import fpec_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, packSign = 1'b0, packIndef = 1'b0;
  logic [79:0] opIn = 80'h0, mRnd = 80'h0, mOp;
  fpec_fmt_t fmtSel = FPEC_HALF, mFmt = FPEC_HALF;
  logic [2:0] mKind = 3'h0;
  logic [14:0] packExp = 15'h0;
  logic [62:0] packFrac = 63'h0;
  logic signOut, intBit, intBitMismatch;
  logic [14:0] expOut;
  logic signed [15:0] unbiasedExp;
  logic [62:0] fracOut;
  logic [63:0] signifOut;
  logic [6:0] classOut;
  logic [3:0] byteCount;
  logic [79:0] packOut;
  int mismatches = 0, num_checks = 0;
  int EW[4] = '{5, 8, 11, 15};
  int FW[4] = '{10, 23, 52, 63};
  int BI[4] = '{15, 127, 1023, 16383};
  int BY[4] = '{2, 4, 8, 10};
  always #4 ref_clk = ~ref_clk;
  fpec_top dut (.ref_clk(ref_clk), .rst(rst), .opIn(opIn), .fmtSel(fmtSel), .packSign(packSign),
    .packExp(packExp), .packFrac(packFrac), .packIndef(packIndef), .signOut(signOut), .expOut(expOut),
    .unbiasedExp(unbiasedExp), .intBit(intBit), .fracOut(fracOut), .signifOut(signifOut),
    .classOut(classOut), .byteCount(byteCount), .packOut(packOut), .intBitMismatch(intBitMismatch));
  fpec_src_model src (.fmt(mFmt), .kind(mKind), .rnd(mRnd), .opnd(mOp));
  task automatic cmp(input logic [79:0] got, input logic [79:0] want, input string what);
    num_checks++;
    if (got !== want) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one operand in, fields worked out here and compared one edge later
  task automatic run1(input fpec_fmt_t f, input logic [79:0] op, input logic ind);
    int ew, fw, ext;
    logic [14:0] ex;
    logic [62:0] fr;
    logic s, ib;
    logic [6:0] cl;
    logic [79:0] pk;
    ew = EW[int'(f)];
    fw = FW[int'(f)];
    ext = (f == FPEC_EXT) ? 1 : 0;
    s = op[ew+fw+ext];
    ex = 15'((op >> (fw + ext)) & ((80'h1 << ew) - 80'h1));
    fr = 63'(op & ((80'h1 << fw) - 80'h1));
    ib = (ext == 1) ? op[63] : (ex != 15'h0);
    cl = 7'h0;
    if (ex == 15'h0) cl[(fr == 63'h0) ? 0 : 1] = 1'b1;
    else if (32'(ex) != (1 << ew) - 1) cl[2] = 1'b1;
    else if (fr == 63'h0) cl[3] = 1'b1;
    else begin
      cl[fr[fw-1] ? 5 : 4] = 1'b1;
      cl[6] = s && (fr == 63'h1 << (fw - 1));
    end
    pk = op & ((80'h1 << (ew + fw + 1 + ext)) - 80'h1);
    if (ext == 1) pk[63] = (ex != 15'h0);
    if (ind) pk = (80'h1 << (ew + fw + ext)) | (((80'h1 << ew) - 80'h1) << (fw + ext)) | (80'h1 << (fw - 1))
      | ((ext == 1) ? (80'h1 << 63) : 80'h0);
    @(posedge ref_clk);
    opIn <= op;
    fmtSel <= f;
    packSign <= s;
    packExp <= ex;
    packFrac <= fr;
    packIndef <= ind;
    @(posedge ref_clk);
    #1;
    cmp(80'(classOut), 80'(cl), "class");
    cmp(80'({signOut, expOut}), 80'({s, ex}), "sign exp");
    cmp(80'(unbiasedExp), 80'(16'(int'(ex) - BI[int'(f)])), "unbias");
    cmp(80'(signifOut), 80'({ib, fr}), "signif");
    cmp(80'({intBit, fracOut}), 80'({ib, fr}), "int frac");
    cmp(80'(intBitMismatch), 80'((ext == 1) && (op[63] != (ex != 15'h0))), "jbit flag");
    cmp(80'(byteCount), 80'(BY[int'(f)]), "bytes");
    cmp(packOut, pk, "pack");
  endtask
  // reset, then every class in every format, then raw random operands
  initial begin
    void'($urandom(32'h1d486b06));
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    cmp(80'(classOut), 80'h0, "reset class");
    for (int f = 0; f < 4; f++) begin
      for (int k = 0; k < 28; k++) begin
        mFmt = fpec_fmt_t'(f);
        mKind = 3'(k % 7);
        mRnd = 80'({$urandom, $urandom, $urandom});
        #1;
        run1(mFmt, mOp, (k % 5) == 4);
      end
      $display("format %0d classes done", f);
    end
    // hand-written corners: quiet nan, minus zero, pseudo zero, unnormal, double indefinite
    run1(FPEC_SINGLE, 80'h0000000000007FC00000, 1'b0);
    run1(FPEC_HALF, 80'h00000000000000008000, 1'b0);
    run1(FPEC_EXT, 80'h00008000000000000000, 1'b0);
    run1(FPEC_EXT, 80'h3FFF0000000000000000, 1'b0);
    run1(FPEC_DOUBLE, 80'h0000FFF8000000000000, 1'b1);
    $display("corner cases done");
    // reset again mid-run: class and pack outputs must drop to zero at the reset edge
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    cmp(80'(classOut), 80'h0, "mid reset class");
    cmp(packOut, 80'h0, "mid reset pack");
    $display("mid-run reset done");
    for (int i = 0; i < 60; i++) run1(fpec_fmt_t'(i % 4), 80'({$urandom, $urandom, $urandom}), 1'b0);
    $display("random operands done");
    end_sim();
  end
endmodule
`default_nettype wire
